// ==== verilog/rx_seq_regs.vh ====
`ifndef RX_SEQ_REGS_VH
`define RX_SEQ_REGS_VH
// Sampling period in ns and core clock period in ns
`define SAMPLE_PERIOD_NS 1600
`define CORE_PERIOD_NS 25
`define SAMPLE_DIV (`SAMPLE_PERIOD_NS / `CORE_PERIOD_NS)
// State codes
`define ST_INIT 4'h0
`define ST_CONFIG 4'h1
`define ST_SLEEP_CNT 4'h2
`define ST_IDWAIT_CNT 4'h3
`define ST_HDRWAIT_CNT 4'h4
`define ST_DATA_CNT 4'h5
`define ST_SLEEP_PIN 4'h6
`define ST_IDWAIT_PIN 4'h7
`define ST_IDSEND_PIN 4'h8
`define ST_HDRWAIT_PIN 4'h9
`define ST_DATA_PIN 4'ha
`define ST_RAW_PIN 4'hb
`define ST_TO_SLEEP 4'hc
// Header time-out in strobe periods
`define HDR_TIMEOUT 7'd66
// Identifier byte shift at 312.5 kBd: two sample periods per bit
`define ID_BIT_TICKS 2'd2
`endif

// ==== verilog/id_shifter.v ====
`timescale 1ns/10ps
`default_nettype none
// Shifts one byte MSB first, one bit per bit_tick
module id_shifter
(
    input wire clk_in,
    input wire rst_n_in,
    input wire load_in,
    input wire [7:0] byte_in,
    input wire bit_tick_in,
    output reg bit_out,
    output wire busy_out
);
    reg [7:0] sh_ff;
    reg [3:0] cnt_ff;
    assign busy_out = (cnt_ff != 4'h0);
    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sh_ff <= 8'h00;
            cnt_ff <= 4'h0;
            bit_out <= 1'b0;
        end
        else if (load_in)
        begin
            sh_ff <= byte_in;
            cnt_ff <= 4'h8;
        end
        else if (bit_tick_in && busy_out)
        begin
            bit_out <= sh_ff[7];
            sh_ff <= {sh_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff - 4'h1;
        end
        else if (!busy_out && bit_tick_in)
        begin
            bit_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/rx_mode_seq.v ====
`include "rx_seq_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module rx_mode_seq
(
    input wire CORE_CLK_IN,
    input wire RESET_N_IN,
    input wire CONFIG_HOLD_N_PIN_IN,
    input wire STROBE_PIN_IN,
    input wire STROBE_OSC_ENABLE_IN,
    input wire [1:0] SLEEP_RUN_RATIO_IN,
    input wire DATA_MANAGER_ENABLE_IN,
    input wire HEADER_PRESENT_FLAG_IN,
    input wire [7:0] ID_WORD_IN,
    input wire STROBE_TICK_IN,
    input wire ID_DETECT_IN,
    input wire ID_COMPL_IN,
    input wire HEADER_DETECT_IN,
    input wire HEADER_COMPL_IN,
    input wire MESSAGE_END_MARK_IN,
    input wire RX_DATA_IN,
    input wire RX_CLK_IN,
    input wire BYTE_DONE_IN,
    input wire DEMOD_IN,
    output reg [3:0] STATE_OUT,
    output reg RECEIVER_ON_OUT,
    output reg STROBE_OSC_ON_OUT,
    output reg SPI_SLAVE_OUT,
    output reg DEMOD_OUT_PIN_OUT,
    output reg MOSI_OUT,
    output reg SCLK_OUT,
    output reg SAMPLE_TICK_OUT
);
    reg [5:0] div_ff;
    reg [3:0] state_ff;
    reg [3:0] nxt_state;
    reg [3:0] target_ff;
    reg [3:0] nxt_target;
    reg [1:0] sleep_wait_ff;
    reg cfg_low_ff;
    reg [4:0] strobe_cnt_ff;
    reg [6:0] timeout_ff;
    reg compl_ff;
    reg pend_stop_ff;
    reg [1:0] bit_div_ff;
    reg id_load;
    wire id_bit;
    wire id_busy;
    wire tick;
    wire bit_tick;

    function [4:0] ratio_of;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: ratio_of = 5'd3;
                2'b01: ratio_of = 5'd7;
                2'b10: ratio_of = 5'd15;
                default: ratio_of = 5'd31;
            endcase
        end
    endfunction

    // sample enable
    // Compared at full integer width so no bits are dropped
    assign tick = ({26'd0, div_ff} == `SAMPLE_DIV - 1);
    assign bit_tick = tick && (bit_div_ff == `ID_BIT_TICKS - 2'd1);

    always @(posedge CORE_CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            div_ff <= 6'h00;
            bit_div_ff <= 2'b00;
        end
        else
        begin
            div_ff <= tick ? 6'h00 : div_ff + 6'h01;
            if (tick)
                bit_div_ff <= bit_tick ? 2'b00 : bit_div_ff + 2'b01;
        end
    end

    id_shifter u_id
    (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .load_in(id_load),
        .byte_in(ID_WORD_IN),
        .bit_tick_in(bit_tick),
        .bit_out(id_bit),
        .busy_out(id_busy)
    );

    wire hdr_on = DATA_MANAGER_ENABLE_IN && HEADER_PRESENT_FLAG_IN;
    wire id_hit = ID_DETECT_IN || ID_COMPL_IN;
    wire hdr_hit = HEADER_DETECT_IN || HEADER_COMPL_IN;
    wire [3:0] sleep_st = STROBE_OSC_ENABLE_IN ? `ST_SLEEP_CNT : `ST_SLEEP_PIN;

    always @*
    begin
        nxt_state = state_ff;
        nxt_target = target_ff;
        id_load = 1'b0;
        case (state_ff)
            `ST_INIT:
                nxt_state = sleep_st;
            `ST_CONFIG:
                if (CONFIG_HOLD_N_PIN_IN)
                begin
                    // leave config to a sleep state
                    nxt_state = sleep_st;
                end
            `ST_SLEEP_CNT:
                if (!STROBE_OSC_ENABLE_IN)
                    nxt_state = `ST_SLEEP_PIN;
                else if (STROBE_PIN_IN ||
                    strobe_cnt_ff == ratio_of(SLEEP_RUN_RATIO_IN))
                    nxt_state = `ST_IDWAIT_CNT;
            `ST_IDWAIT_CNT:
                if (id_hit)
                    nxt_state = hdr_on ? `ST_HDRWAIT_CNT : `ST_DATA_CNT;
                else if (STROBE_TICK_IN && !STROBE_PIN_IN)
                begin
                    nxt_state = `ST_TO_SLEEP;
                    nxt_target = `ST_SLEEP_CNT;
                end
            `ST_HDRWAIT_CNT:
                if (hdr_hit)
                    nxt_state = `ST_DATA_CNT;
                else if (timeout_ff >= `HDR_TIMEOUT)
                begin
                    nxt_state = `ST_TO_SLEEP;
                    nxt_target = `ST_SLEEP_CNT;
                end
            `ST_DATA_CNT:
                if (pend_stop_ff && BYTE_DONE_IN)
                begin
                    nxt_state = `ST_TO_SLEEP;
                    nxt_target = `ST_SLEEP_CNT;
                end
            `ST_SLEEP_PIN:
                if (STROBE_OSC_ENABLE_IN)
                    nxt_state = `ST_SLEEP_CNT;
                else if (STROBE_PIN_IN)
                    nxt_state = `ST_IDWAIT_PIN;
            `ST_IDWAIT_PIN:
                if (id_hit)
                begin
                    nxt_state = `ST_IDSEND_PIN;
                    id_load = 1'b1;
                end
            // Leave on a bit tick so the last ID bit keeps its full width
            `ST_IDSEND_PIN:
                if (!id_busy && bit_tick)
                    nxt_state = hdr_on ? `ST_HDRWAIT_PIN : `ST_DATA_PIN;
            `ST_HDRWAIT_PIN:
                if (hdr_hit)
                    nxt_state = `ST_DATA_PIN;
            `ST_DATA_PIN:
                if (MESSAGE_END_MARK_IN)
                    nxt_state = `ST_RAW_PIN;
            `ST_RAW_PIN:
                nxt_state = `ST_RAW_PIN;
            `ST_TO_SLEEP:
                if (sleep_wait_ff == 2'd1)
                    nxt_state = target_ff;
            default:
                nxt_state = `ST_INIT;
        endcase
        // strobe low in pin run states
        if (!STROBE_OSC_ENABLE_IN && !STROBE_PIN_IN &&
            state_ff >= `ST_IDWAIT_PIN && state_ff <= `ST_RAW_PIN)
        begin
            if (state_ff != `ST_DATA_PIN || BYTE_DONE_IN)
            begin
                nxt_state = `ST_TO_SLEEP;
                nxt_target = `ST_SLEEP_PIN;
            end
        end
        if (!STROBE_OSC_ENABLE_IN &&
            state_ff >= `ST_IDWAIT_CNT && state_ff <= `ST_HDRWAIT_CNT)
        begin
            nxt_state = `ST_TO_SLEEP;
            nxt_target = `ST_SLEEP_PIN;
        end
        if (cfg_low_ff && !CONFIG_HOLD_N_PIN_IN)
            nxt_state = `ST_CONFIG;
    end

    always @(posedge CORE_CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            state_ff <= `ST_INIT;
            target_ff <= `ST_SLEEP_CNT;
            sleep_wait_ff <= 2'd0;
            cfg_low_ff <= 1'b0;
            strobe_cnt_ff <= 5'd0;
            timeout_ff <= 7'd0;
            compl_ff <= 1'b0;
            pend_stop_ff <= 1'b0;
        end
        else if (tick)
        begin
            cfg_low_ff <= !CONFIG_HOLD_N_PIN_IN;
            state_ff <= nxt_state;
            target_ff <= nxt_target;
            if (nxt_state == `ST_TO_SLEEP && state_ff != `ST_TO_SLEEP)
                sleep_wait_ff <= 2'd2;
            else if (sleep_wait_ff != 2'd0)
                sleep_wait_ff <= sleep_wait_ff - 2'd1;
            if (state_ff != `ST_SLEEP_CNT)
                strobe_cnt_ff <= 5'd0;
            else if (STROBE_TICK_IN)
                strobe_cnt_ff <= strobe_cnt_ff + 5'd1;
            if (state_ff != `ST_HDRWAIT_CNT)
                timeout_ff <= 7'd0;
            else if (STROBE_TICK_IN)
                timeout_ff <= timeout_ff + 7'd1;
            if (HEADER_COMPL_IN && hdr_hit)
                compl_ff <= 1'b1;
            else if (state_ff == `ST_SLEEP_CNT || state_ff == `ST_SLEEP_PIN)
                compl_ff <= 1'b0;
            if (state_ff == `ST_DATA_CNT && MESSAGE_END_MARK_IN)
                pend_stop_ff <= 1'b1;
            else if (state_ff != `ST_DATA_CNT)
                pend_stop_ff <= 1'b0;
        end
    end

    // Outputs are registered so the pins never glitch on decode
    always @(posedge CORE_CLK_IN)
    begin
        if (!RESET_N_IN)
        begin
            STATE_OUT <= `ST_INIT;
            RECEIVER_ON_OUT <= 1'b0;
            STROBE_OSC_ON_OUT <= 1'b0;
            SPI_SLAVE_OUT <= 1'b0;
            DEMOD_OUT_PIN_OUT <= 1'b0;
            MOSI_OUT <= 1'b0;
            SCLK_OUT <= 1'b0;
            SAMPLE_TICK_OUT <= 1'b0;
        end
        else
        begin
            STATE_OUT <= state_ff;
            SAMPLE_TICK_OUT <= tick;
            RECEIVER_ON_OUT <= !(state_ff == `ST_SLEEP_CNT ||
                state_ff == `ST_SLEEP_PIN || state_ff == `ST_TO_SLEEP);
            STROBE_OSC_ON_OUT <= STROBE_OSC_ENABLE_IN;
            // slave only in config; demod is copied in every state
            SPI_SLAVE_OUT <= (state_ff == `ST_CONFIG);
            DEMOD_OUT_PIN_OUT <= DEMOD_IN;
            MOSI_OUT <= 1'b0;
            SCLK_OUT <= 1'b0;
            case (state_ff)
                `ST_IDSEND_PIN:
                    MOSI_OUT <= id_bit;
                `ST_DATA_CNT, `ST_DATA_PIN:
                    // raw without framing when manager off
                    if (DATA_MANAGER_ENABLE_IN)
                    begin
                        MOSI_OUT <= RX_DATA_IN ^ compl_ff;
                        SCLK_OUT <= RX_CLK_IN;
                    end
                    else
                        MOSI_OUT <= RX_DATA_IN;
                `ST_RAW_PIN:
                    MOSI_OUT <= RX_DATA_IN;
                default:
                    MOSI_OUT <= 1'b0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== verif/rx_mode_seq_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rx_seq_regs.vh"
module rx_mode_seq_monitor
(
    input wire CORE_CLK_IN,
    input wire RESET_N_IN,
    input wire CONFIG_HOLD_N_PIN_IN,
    input wire STROBE_PIN_IN,
    input wire DEMOD_IN,
    input wire [3:0] STATE_OUT,
    input wire DEMOD_OUT_PIN_OUT,
    input wire SCLK_OUT,
    input wire SAMPLE_TICK_OUT
);
wire in_cfg = STATE_OUT == `ST_CONFIG;
reg [1:0] low_ff;
// Ticks that saw the config pin low, saturating at three
always @(posedge CORE_CLK_IN)
begin
    if (!RESET_N_IN || CONFIG_HOLD_N_PIN_IN)
        low_ff <= 2'h0;
    else if (SAMPLE_TICK_OUT && low_ff != 2'h3)
        low_ff <= low_ff + 2'h1;
end
default clocking cb @(posedge CORE_CLK_IN);
endclocking
default disable iff (!RESET_N_IN);
a_tick_spacing: assert property (
    SAMPLE_TICK_OUT |=> !SAMPLE_TICK_OUT [*8] ##56 SAMPLE_TICK_OUT)
    else $error("tick spacing wrong");
a_state_on_tick: assert property (
    $changed(STATE_OUT) |-> $past(SAMPLE_TICK_OUT, 1) ||
    $past(SAMPLE_TICK_OUT, 2) || $past(SAMPLE_TICK_OUT, 3))
    else $error("state moved off tick");
a_cfg_hold: assert property (
    in_cfg && !CONFIG_HOLD_N_PIN_IN |=> in_cfg)
    else $error("left config while held");
a_cfg_entry: assert property (
    low_ff == 2'h3 |-> ##[0:130] in_cfg)
    else $error("config not entered");
a_cfg_leave: assert property (
    $past(in_cfg) && !in_cfg |-> ##[0:200]
    (STATE_OUT == `ST_SLEEP_CNT || STATE_OUT == `ST_SLEEP_PIN))
    else $error("slow config exit");
a_demod_copy: assert property (
    in_cfg |-> DEMOD_OUT_PIN_OUT == $past(DEMOD_IN))
    else $error("demod pin not copied");
a_pin_drop: assert property (
    STATE_OUT == `ST_IDWAIT_PIN && !STROBE_PIN_IN && CONFIG_HOLD_N_PIN_IN
    |-> ##[1:330] STATE_OUT == `ST_SLEEP_PIN)
    else $error("no pin sleep");
a_raw_noclk: assert property (
    STATE_OUT == `ST_RAW_PIN && $past(STATE_OUT) == `ST_RAW_PIN |-> !SCLK_OUT)
    else $error("clock in raw state");
endmodule
bind rx_mode_seq rx_mode_seq_monitor i_mon (.*);
`default_nettype wire

// ==== verif/host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module host_model
(
    input wire clk_in,
    input wire tick_in,
    input wire mosi_in,
    output reg [31:0] hist_out
);
// host never opens an SPI transfer, it only listens
// Paced ID byte carries no clock, so sample once per tick
always @(posedge clk_in)
begin
    if (tick_in)
        hist_out <= {hist_out[30:0], mosi_in};
end
endmodule
`default_nettype wire

// ==== verif/rx_mode_seq_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "rx_seq_regs.vh"
module rx_mode_seq_test;
reg clk = 1'b0;
reg rst_n = 1'b0, cfg_n = 1'b1, stb = 1'b0, strobe_osc_enable = 1'b1, data_manager_enable = 1'b1;
reg he = 1'b0, sti = 1'b0, idd = 1'b0, idc = 1'b0, hdd = 1'b0, hdc = 1'b0;
reg message_end_mark = 1'b0, rxd = 1'b0, rxc = 1'b0, bdn = 1'b0, dem = 1'b0, ok;
reg [1:0] sr = 2'h0;
reg [15:0] e16;
wire [3:0] st;
wire rxon, oscon, slv, dmo, mosi, sclk, tk;
wire [31:0] hist;
integer n_fail = 0, total_checks = 0, i, k;
localparam [7:0] IDW = 8'ha5;
rx_mode_seq i_dut
(
    .CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CONFIG_HOLD_N_PIN_IN(cfg_n),
    .STROBE_PIN_IN(stb), .STROBE_OSC_ENABLE_IN(strobe_osc_enable), .SLEEP_RUN_RATIO_IN(sr),
    .DATA_MANAGER_ENABLE_IN(data_manager_enable), .HEADER_PRESENT_FLAG_IN(he),
    .ID_WORD_IN(IDW), .STROBE_TICK_IN(sti), .ID_DETECT_IN(idd),
    .ID_COMPL_IN(idc), .HEADER_DETECT_IN(hdd), .HEADER_COMPL_IN(hdc),
    .MESSAGE_END_MARK_IN(message_end_mark), .RX_DATA_IN(rxd), .RX_CLK_IN(rxc),
    .BYTE_DONE_IN(bdn), .DEMOD_IN(dem), .STATE_OUT(st),
    .RECEIVER_ON_OUT(rxon), .STROBE_OSC_ON_OUT(oscon), .SPI_SLAVE_OUT(slv),
    .DEMOD_OUT_PIN_OUT(dmo), .MOSI_OUT(mosi), .SCLK_OUT(sclk),
    .SAMPLE_TICK_OUT(tk)
);
host_model i_host (.clk_in(clk), .tick_in(tk), .mosi_in(mosi), .hist_out(hist));
initial
    forever #12.5 clk = ~clk;
task final_report;
begin
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
end
endtask
task chk(input string nm, input [15:0] e, input [15:0] g);
begin
    total_checks = total_checks + 1;
    if (g !== e)
    begin
        n_fail = n_fail + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
    end
end
endtask
// Returns at the falling edge just after a sample tick
task ticks(input integer n);
integer j, c;
begin
    for (j = 0; j < n; j = j + 1)
    begin
        c = 0;
        @(negedge clk);
        while (tk !== 1'b1 && c < 80)
        begin
            c = c + 1;
            @(negedge clk);
        end
        if (c == 80)
        begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
end
endtask
task wst(input [3:0] s, input integer n);
integer j;
begin
    j = 0;
    while (st !== s && j < n)
    begin
        ticks(1);
        @(negedge clk);
        j = j + 1;
    end
    chk("state", s, st);
end
endtask
// One strobe period: the strobe tick spans a whole sample period
task sp(input integer n);
integer j;
begin
    for (j = 0; j < n; j = j + 1)
    begin
        ticks(1);
        sti = 1'b1;
        ticks(1);
        sti = 1'b0;
    end
end
endtask
task cfg(input [3:0] s);
begin
    cfg_n = 1'b0;
    wst(`ST_CONFIG, 4);
    cfg_n = 1'b1;
    wst(s, 4);
end
endtask
task to_hdr;
begin
    stb = 1'b1;
    wst(`ST_IDWAIT_CNT, 3);
    stb = 1'b0;
    idc = 1'b1;
    wst(`ST_HDRWAIT_CNT, 3);
    idc = 1'b0;
end
endtask
task pin10;
begin
    stb = 1'b1;
    wst(`ST_IDWAIT_PIN, 3);
    idd = 1'b1;
    wst(`ST_IDSEND_PIN, 3);
    idd = 1'b0;
    // strobe held high through ID send and header wait
    wst(`ST_HDRWAIT_PIN, 24);
    hdd = 1'b1;
    wst(`ST_DATA_PIN, 3);
    hdd = 1'b0;
end
endtask
initial
begin
    repeat (8) @(negedge clk);
    chk("init", `ST_INIT, st);
    rst_n = 1'b1;
    // One low tick alone must be ignored
    cfg_n = 1'b0;
    ticks(1);
    cfg_n = 1'b1;
    ticks(3);
    chk("refuse", 1'b0, st === `ST_CONFIG);
    cfg_n = 1'b0;
    dem = 1'b1;
    wst(`ST_CONFIG, 4);
    ticks(6);
    chk("hold", `ST_CONFIG, st);
    chk("slave", 3'h7, {slv, rxon, dmo});
    chk("spi", 2'h0, {mosi, sclk});
    cfg_n = 1'b1;
    wst(`ST_SLEEP_CNT, 4);
    chk("osc", 2'h2, {oscon, rxon});
    $display("test config done");
    for (k = 0; k < 4; k = k + 1)
    begin
        sr = k[1:0];
        cfg(`ST_SLEEP_CNT);
        sp((4 << k) - 2);
        chk("early", `ST_SLEEP_CNT, st);
        sp(1);
        wst(`ST_IDWAIT_CNT, 3);
    end
    sp(1);
    wst(`ST_SLEEP_CNT, 4);
    $display("test ratio done");
    for (k = 0; k < 3; k = k + 1)
    begin
        data_manager_enable = (k != 2);
        he = (k != 0);
        stb = 1'b1;
        wst(`ST_IDWAIT_CNT, 3);
        stb = 1'b0;
        idd = 1'b1;
        wst(k == 1 ? `ST_HDRWAIT_CNT : `ST_DATA_CNT, 3);
        idd = 1'b0;
        cfg(`ST_SLEEP_CNT);
    end
    data_manager_enable = 1'b1;
    to_hdr;
    sp(64);
    chk("timeout", `ST_HDRWAIT_CNT, st);
    sp(3);
    wst(`ST_SLEEP_CNT, 4);
    to_hdr;
    hdc = 1'b1;
    wst(`ST_DATA_CNT, 3);
    hdc = 1'b0;
    rxd = 1'b1;
    ticks(2);
    chk("compl", 1'b0, mosi);
    message_end_mark = 1'b1;
    bdn = 1'b1;
    wst(`ST_TO_SLEEP, 3);
    bdn = 1'b0;
    wst(`ST_SLEEP_CNT, 3);
    message_end_mark = 1'b0;
    $display("test counter done");
    strobe_osc_enable = 1'b0;
    cfg(`ST_SLEEP_PIN);
    chk("off", 2'h0, {oscon, rxon});
    stb = 1'b1;
    wst(`ST_IDWAIT_PIN, 3);
    ticks(4);
    chk("stay", `ST_IDWAIT_PIN, st);
    stb = 1'b0;
    wst(`ST_SLEEP_PIN, 4);
    pin10;
    // Each ID bit spans two sample ticks, MSB first
    for (i = 0; i < 8; i = i + 1)
        e16[15 - 2 * i -: 2] = {2{IDW[7 - i]}};
    ok = 1'b0;
    for (i = 0; i < 17; i = i + 1)
        if (hist[i +: 16] === e16)
            ok = 1'b1;
    chk("idbyte", 1'b1, ok);
    stb = 1'b0;
    ticks(6);
    chk("byte", `ST_DATA_PIN, st);
    bdn = 1'b1;
    wst(`ST_SLEEP_PIN, 4);
    bdn = 1'b0;
    pin10;
    message_end_mark = 1'b1;
    wst(`ST_RAW_PIN, 3);
    for (i = 0; i < 4; i = i + 1)
    begin
        rxc = ~rxc;
        rxd = ~rxd;
        ticks(1);
        @(negedge clk);
        chk("raw", {1'b0, rxd}, {sclk, mosi});
    end
    $display("test pin done");
    final_report;
end
endmodule
`default_nettype wire
